// ### rtl/logic_cell_defines.vh
// Notes on behaviour
// - The fourth data selector is six bits in bits 5 to 0 of its register, and bits 7 and 6 read as zero.
// - Each of the four selected data inputs gives a true and an inverted copy, each with its own enable bit per gate.
// - Gate 1 ORs the copies enabled by its mask, bits 7 to 0 being d4 true, d4 inverted, down to d1 inverted.
// - Gate 2 has its own 8-bit mask in the same order, where a one includes and a zero excludes a copy.
// - Gate 3 has a third 8-bit mask in the same order, bit 7 for d4 true and bit 0 for d1 inverted.
// - All implemented selector and mask bits are read/write, cleared by reset, changed only by bus writes and kept otherwise.
// - Data inputs 1, 2 and 3 have matching 6-bit selectors that pick one of the cell input signals.
// - Each gate output can be inverted by its own polarity bit, a one selecting inversion.
`ifndef LOGIC_CELL_DEFINES_VH
`define LOGIC_CELL_DEFINES_VH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define ADDR_W        8
`define OFS_SEL_BASE  8'h00
`define OFS_MASK_BASE 8'h10
`define REG_STRIDE    8'h04
`define OFS_POL       8'h1C
`define OFS_STATUS    8'h20

// ----------------------------------------------------------------------
// Field layout
// ----------------------------------------------------------------------
`define SEL_W         6
`define MASK_W        8
`define POL_W         3
`define DATA_N        4
`define GATE_N        3
`define COPY_INV      0
`define COPY_TRUE     1
`define STAT_DATA_LSB 0
`define STAT_GATE_LSB 4

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_SEL       6'h00
`define RST_MASK      8'h00
`define RST_POL       3'h0
`define RST_DATA      32'h00000000

`endif

// ### rtl/input_selector.v
`timescale 1ns/100ps
module input_selector #(
  parameter NUM_INPUTS = 64,
  parameter SEL_W      = 6
) (
  // Candidate signals and choice
  input  wire [NUM_INPUTS-1:0] candidates,
  input  wire [SEL_W-1:0]      choice,
  // Selected signal
  output wire                  picked
);

  // A choice beyond the populated inputs reads as zero rather than unknown.
  assign picked = (choice < NUM_INPUTS) ? candidates[choice] : 1'b0;

endmodule

// ### rtl/logic_cell_input_gating.v
`timescale 1ns/100ps
`include "logic_cell_defines.vh"
module logic_cell_input_gating #(
  parameter NUM_INPUTS = 64
) (
  // Clock and reset
  input  wire                  pclk,
  input  wire                  presetn,
  // APB slave
  input  wire                  psel,
  input  wire                  penable,
  input  wire                  pwrite,
  input  wire [`ADDR_W-1:0]    paddr,
  input  wire [31:0]           pwdata,
  output reg  [31:0]           prdata,
  output wire                  pready,
  output wire                  pslverr,
  // Cell input signals, from outside this clock domain
  input  wire [NUM_INPUTS-1:0] cell_inputs,
  // Gate outputs after polarity
  output reg                   gate_one_output,
  output reg                   gate_two_output,
  output reg                   gate_three_output
);

  // --------------------------------------------------------------------
  // Input synchroniser
  // --------------------------------------------------------------------
  // Only the second stage feeds logic, so a selected input lags its pin by two clocks.
  // A pulse on a pin shorter than one clock period may be missed altogether.
  reg  [NUM_INPUTS-1:0] inputs_meta;
  reg  [NUM_INPUTS-1:0] inputs_sync;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inputs_meta <= {NUM_INPUTS{1'b0}};
      inputs_sync <= {NUM_INPUTS{1'b0}};
    end else begin
      inputs_meta <= cell_inputs;
      inputs_sync <= inputs_meta;
    end
  end

  // --------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------
  wire                      setup_phase;
  wire                      access_phase;
  wire                      wr_access;
  wire                      rd_setup;
  wire [`DATA_N-1:0]        sel_hit;
  wire [`GATE_N-1:0]        mask_hit;
  wire                      pol_hit;
  wire                      status_hit;
  wire                      addr_ok;
  wire [`DATA_N-1:0]        sel_write;
  wire [`GATE_N-1:0]        mask_write;
  wire                      pol_write;

  assign setup_phase  = psel & ~penable;
  assign access_phase = psel & penable;
  assign wr_access    = access_phase & pwrite;
  assign rd_setup     = setup_phase & ~pwrite;
  assign pol_hit      = (paddr == `OFS_POL);
  assign status_hit   = (paddr == `OFS_STATUS);
  // The status word counts as mapped, so a write to it is dropped without an error.
  assign addr_ok      = (|sel_hit) | (|mask_hit) | pol_hit | status_hit;
  assign pol_write    = wr_access & pol_hit;
  // Every register answers at once, so the access phase never stretches.
  assign pready       = 1'b1;
  // An unmapped access is refused with an error, and a write there changes nothing.
  assign pslverr      = access_phase & ~addr_ok;

  // --------------------------------------------------------------------
  // Data selectors
  // --------------------------------------------------------------------
  // Selector and mask bits have no defined power-on value in the cell; zero is used here.
  reg  [`DATA_N*`SEL_W-1:0] selectors;
  wire [`DATA_N-1:0]        data_picked;
  wire [2*`DATA_N-1:0]      copies;

  genvar d;
  generate
    for (d = 0; d < `DATA_N; d = d + 1) begin : g_data
      // The offset is formed at full width and cut to the bus width on purpose.
      localparam [31:0]        SEL_OFS_WIDE = `OFS_SEL_BASE + d * `REG_STRIDE;
      localparam [`ADDR_W-1:0] SEL_OFS      = SEL_OFS_WIDE[`ADDR_W-1:0];
      assign sel_hit[d]   = (paddr == SEL_OFS);
      assign sel_write[d] = wr_access & sel_hit[d];

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          selectors[d*`SEL_W +: `SEL_W] <= `RST_SEL;
        end else if (sel_write[d]) begin
          selectors[d*`SEL_W +: `SEL_W] <= pwdata[`SEL_W-1:0];
        end
      end

      input_selector #(
        .NUM_INPUTS (NUM_INPUTS),
        .SEL_W      (`SEL_W)
      ) u_select (
        .candidates (inputs_sync),
        .choice     (selectors[d*`SEL_W +: `SEL_W]),
        .picked     (data_picked[d])
      );

      assign copies[2*d + `COPY_TRUE] = data_picked[d];
      assign copies[2*d + `COPY_INV]  = ~data_picked[d];
    end
  endgenerate

  // --------------------------------------------------------------------
  // Gate enable masks
  // --------------------------------------------------------------------
  // Each mask holds eight enables, one per data copy, the top bit for data 4 true.
  reg  [`GATE_N*`MASK_W-1:0] masks;
  reg  [`POL_W-1:0]          gate_invert;
  wire [`GATE_N-1:0]         gate_raw;
  wire [`GATE_N-1:0]         next_gate;

  genvar g;
  generate
    for (g = 0; g < `GATE_N; g = g + 1) begin : g_gate
      // The offset is formed at full width and cut to the bus width on purpose.
      localparam [31:0]        MASK_OFS_WIDE = `OFS_MASK_BASE + g * `REG_STRIDE;
      localparam [`ADDR_W-1:0] MASK_OFS      = MASK_OFS_WIDE[`ADDR_W-1:0];
      assign mask_hit[g]   = (paddr == MASK_OFS);
      assign mask_write[g] = wr_access & mask_hit[g];

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          masks[g*`MASK_W +: `MASK_W] <= `RST_MASK;
        end else if (mask_write[g]) begin
          masks[g*`MASK_W +: `MASK_W] <= pwdata[`MASK_W-1:0];
        end
      end

      // A mask of zero keeps its gate low ahead of the polarity stage.
      // OR of enabled
      assign gate_raw[g]  = |(masks[g*`MASK_W +: `MASK_W] & copies);
      assign next_gate[g] = gate_raw[g] ^ gate_invert[g];
    end
  endgenerate

  // --------------------------------------------------------------------
  // Gate polarity
  // --------------------------------------------------------------------
  // The inversion sits ahead of the output flop, so a polarity write shows one edge later.
  // Keeping it there costs nothing and leaves the outputs free of glitches on a change.
  // polarity register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_invert <= `RST_POL;
    end else if (pol_write) begin
      gate_invert <= pwdata[`POL_W-1:0];
    end
  end

  // --------------------------------------------------------------------
  // Gate outputs
  // --------------------------------------------------------------------
  // Registering costs one cycle but keeps glitches off the outputs.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_one_output   <= 1'b0;
      gate_two_output   <= 1'b0;
      gate_three_output <= 1'b0;
    end else begin
      gate_one_output   <= next_gate[0];
      gate_two_output   <= next_gate[1];
      gate_three_output <= next_gate[2];
    end
  end

  // --------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------
  // Status shows the gate outputs as they stand, one edge behind the masks.
  wire [`GATE_N-1:0] gate_now;
  reg  [31:0]        next_prdata;
  integer            k;

  assign gate_now = {gate_three_output, gate_two_output, gate_one_output};

  // Bits above each field are never set here, so unimplemented bits read as zero.
  always @* begin
    next_prdata = `RST_DATA;
    for (k = 0; k < `DATA_N; k = k + 1) begin
      if (sel_hit[k]) begin
        next_prdata[`SEL_W-1:0] = selectors[k*`SEL_W +: `SEL_W];
      end
    end
    for (k = 0; k < `GATE_N; k = k + 1) begin
      if (mask_hit[k]) begin
        next_prdata[`MASK_W-1:0] = masks[k*`MASK_W +: `MASK_W];
      end
    end
    if (pol_hit) begin
      next_prdata[`POL_W-1:0] = gate_invert;
    end
    if (status_hit) begin
      next_prdata[`STAT_DATA_LSB +: `DATA_N] = data_picked;
      next_prdata[`STAT_GATE_LSB +: `GATE_N] = gate_now;
    end
  end

  // Read data is captured in the setup cycle and held through the access.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `RST_DATA;
    end else if (rd_setup) begin
      prdata <= next_prdata;
    end
  end

endmodule

// ### sim/logic_cell_input_gating_properties.sv
`timescale 1ns/100ps
module logic_cell_input_gating_properties #(
  parameter NUM_INPUTS = 64
) (
  // Clock and reset
  input logic                  pclk,
  input logic                  presetn,
  // APB slave
  input logic                  psel,
  input logic                  penable,
  input logic                  pwrite,
  input logic [7:0]            paddr,
  input logic [31:0]           pwdata,
  input logic [31:0]           prdata,
  input logic                  pready,
  input logic                  pslverr,
  // Cell side
  input logic [NUM_INPUTS-1:0] cell_inputs,
  input logic                  gate_one_output,
  input logic                  gate_two_output,
  input logic                  gate_three_output
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Read data is captured at the setup edge, so each check looks one edge later.
  wire rd = psel & ~penable & ~pwrite;
  property p_sel4; rd && paddr == 8'h0C |=> prdata[31:6] == 0; endproperty
  property p_sel13; rd && paddr < 8'h0C && paddr[1:0] == 0 |=> prdata[31:6] == 0; endproperty
  property p_mask;
    rd && (paddr == 8'h10 || paddr == 8'h14 || paddr == 8'h18) |=> prdata[31:8] == 0;
  endproperty
  property p_pol; rd && paddr == 8'h1C |=> prdata[31:3] == 0; endproperty
  property p_stat;
    rd && paddr == 8'h20 |=> prdata[31:7] == 0 &&
      prdata[6:4] == $past({gate_three_output, gate_two_output, gate_one_output});
  endproperty
  property p_bad; psel && penable && !pwrite && paddr > 8'h20 |-> pslverr && prdata == 0; endproperty
  property p_hold; !rd |=> $stable(prdata); endproperty
  property p_wb;
    psel && penable && pwrite && paddr == 8'h14 ##2 rd && paddr == 8'h14
      |=> prdata[7:0] == $past(pwdata[7:0], 3);
  endproperty
  a_sel4: assert property (p_sel4) else $error("selector 4 high bits set");
  a_sel13: assert property (p_sel13) else $error("selector high bits set");
  a_mask: assert property (p_mask) else $error("mask high bits set");
  a_pol: assert property (p_pol) else $error("polarity high bits set");
  a_stat: assert property (p_stat) else $error("status not gate outputs");
  a_bad: assert property (p_bad) else $error("unmapped read not refused");
  a_hold: assert property (p_hold) else $error("read data moved");
  a_wb: assert property (p_wb) else $error("mask readback wrong");
  c_bad: cover property (psel && penable && pslverr);
  c_wb: cover property (psel && penable && pwrite && paddr == 8'h14 ##2 rd && paddr == 8'h14);
  c_stat: cover property (rd && paddr == 8'h20 ##1 prdata[6:4] != 0);
endmodule

// ### sim/tb_top.sv
`timescale 1ns/100ps
`define CHK(n, e, a) begin comparisons++; if ((e) !== (a)) begin n_fail++; \
  $display("Error %s exp %h got %h", n, e, a); end end
module tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        gate_one_output, gate_two_output, gate_three_output;
  logic [2:0]  gates;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, seed, v[8];
  logic [63:0] cell_inputs;
  logic [32:0] q[$], e;
  logic [3:0]  d;
  int          n_fail, comparisons;
  logic_cell_input_gating #(.NUM_INPUTS(64)) uut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .cell_inputs, .gate_one_output,
    .gate_two_output, .gate_three_output);
  function automatic logic [31:0] nx(input logic [31:0] l);
    return {l[30:0], l[31] ^ l[21] ^ l[1] ^ l[0]};
  endfunction
  function automatic logic [31:0] msk(input int i);
    return i < 4 ? 32'h0000003F : i < 7 ? 32'h000000FF : 32'h00000007;
  endfunction
  function automatic logic [32:0] stat();
    logic [2:0] g;
    d = {cell_inputs[v[3][5:0]], cell_inputs[v[2][5:0]], cell_inputs[v[1][5:0]],
         cell_inputs[v[0][5:0]]};
    for (int k = 0; k < 3; k++)
      g[k] = (|(v[4+k][7:0] & {d[3], ~d[3], d[2], ~d[2], d[1], ~d[1], d[0], ~d[0]})) ^ v[7][k];
    return {26'h0, g, d};
  endfunction
  // Entered just after a rising edge; one idle edge follows so psel is never set twice at once.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] dat, input logic [32:0] x);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dat;
    if (!w) q.push_back(x);
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (!pready) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task test_done;
    if (n_fail == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  assign gates = {gate_three_output, gate_two_output, gate_one_output};
  always @(posedge pclk) if (psel && penable && pready && !pwrite) begin
    e = q.pop_front();
    `CHK("read", e, {pslverr, prdata})
    if (paddr == 8'h20) `CHK("gates", e[6:4], gates)
  end
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  initial begin
    #80000;
    n_fail++;
    test_done;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, cell_inputs} = '0;
    seed = 32'h99EBA081;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      v[i] = 0;
      apb(1'b0, 8'(4 * i), 0, 0);
    end
    apb(1'b1, 8'h20, '1, 0);
    apb(1'b1, 8'h24, '1, 0);
    apb(1'b0, 8'h24, 0, 33'h100000000);
    apb(1'b0, 8'h20, 0, stat());
    for (int n = 0; n < 16; n++) begin
      seed = nx(seed);
      cell_inputs[31:0] <= seed;
      seed = nx(seed);
      cell_inputs[63:32] <= seed;
      for (int i = 0; i < 8; i++) begin
        seed = nx(seed);
        v[i] = seed & msk(i);
        apb(1'b1, 8'(4 * i), seed, 0);
        apb(1'b0, 8'(4 * i), 0, {1'b0, v[i]});
      end
      apb(1'b0, 8'h20, 0, stat());
    end
    test_done;
  end
endmodule
bind logic_cell_input_gating logic_cell_input_gating_properties #(.NUM_INPUTS(NUM_INPUTS)) u_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .cell_inputs, .gate_one_output, .gate_two_output, .gate_three_output);
